/* File: twe_dev.sv */
/*
 EEPROM end: decodes instructions from the serial link, keeps the array,
 runs the self-timed programming cycle and returns read data or status.
 Assumes link pins and the width strap are asynchronous to core_clk and
 that the serial clock stays well below core_clk/6.
*/
`include "twe_map.svh"
module twe_dev #(
	parameter int unsigned PROG_CYC = `TWE_PROG_CYC
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic width_select,
	output logic busy,
	output logic prog_enabled,
	twe_if.dev bus
);
	import twe_pkg::*;
	localparam int PTW = $clog2(PROG_CYC);
	logic [7:0] mem_r [0:511];
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic sk_d_r;
	logic org_r;
	twe_dst_type st_r;
	logic [15:0] sh_r;
	logic [4:0] cnt_r;
	logic [8:0] adr_r;
	logic write_all_cmd_r;
	logic we_r;
	logic [8:0] ptr_r;
	logic [15:0] wd_r;
	logic [4:0] bi_r;
	logic so_r;
	logic so_oe_r;
	logic busy_r;
	logic [PTW-1:0] pt_r;
	logic wa_r;
	logic [8:0] pa_r;
	logic [8:0] pe_r;
	logic [15:0] pd_r;
	logic cs_in;
	logic si_in;
	logic sk_rise;
	logic [4:0] ab;
	logic [4:0] db;
	logic [15:0] sh_nxt;
	logic [1:0] opc;
	logic [1:0] sub;
	logic [8:0] adr;
	logic at_addr;
	logic at_data;
	logic go;
	logic go_all;
	logic [15:0] go_dat;
	logic [8:0] go_adr;

	function automatic logic [15:0] rdw(input logic [8:0] a, input logic w16);
		if (w16)
			return {mem_r[{a[7:0], 1'b0}], mem_r[{a[7:0], 1'b1}]};
		return {8'h00, mem_r[a]};
	endfunction

	// Pin synchronisers: {strap, data in, clock, select}
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= 4'h8;
			s2_r <= 4'h8;
			sk_d_r <= 1'b0;
		end else begin
			s1_r <= {width_select, bus.si, bus.sk, bus.cs};
			s2_r <= s1_r;
			sk_d_r <= s2_r[1];
		end
	end

	assign cs_in = s2_r[0];
	assign si_in = s2_r[2];
	assign sk_rise = s2_r[1] & ~sk_d_r;
	assign ab = org_r ? `TWE_ABITS_X16 : `TWE_ABITS_X8;
	assign db = org_r ? `TWE_DBITS_X16 : `TWE_DBITS_X8;
	assign sh_nxt = {sh_r[14:0], si_in};
	assign opc = org_r ? sh_nxt[9:8] : sh_nxt[10:9];
	assign adr = org_r ? {1'b0, sh_nxt[7:0]} : sh_nxt[8:0];
	assign sub = org_r ? adr[7:6] : adr[8:7];
	assign at_addr = sk_rise && st_r == TWE_D_CMD && cnt_r == ab + 5'h01;
	assign at_data = sk_rise && st_r == TWE_D_DATA && cnt_r == db - 5'h01;

	// Organisation is taken from the strap while deselected
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			org_r <= 1'b1;
		else if (st_r == TWE_D_IDLE)
			org_r <= s2_r[3];
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			st_r <= TWE_D_IDLE;
		else if (!cs_in)
			st_r <= TWE_D_IDLE;
		else begin
			unique case (st_r)
				TWE_D_IDLE: st_r <= busy_r ? TWE_D_STAT : TWE_D_START;
				TWE_D_START: if (sk_rise && si_in) st_r <= TWE_D_CMD;
				TWE_D_CMD: if (at_addr) begin
					unique case (opc)
						`TWE_OP_READ: st_r <= TWE_D_READ;
						`TWE_OP_WRITE: st_r <= TWE_D_DATA;
						`TWE_OP_ERASE: st_r <= TWE_D_HOLD;
						`TWE_OP_EXT: st_r <= sub == `TWE_SUB_WRITE_ALL_CMD ? TWE_D_DATA : TWE_D_HOLD;
					endcase
				end
				TWE_D_DATA: if (at_data) st_r <= TWE_D_HOLD;
				TWE_D_READ, TWE_D_STAT, TWE_D_HOLD: st_r <= st_r;
			endcase
		end
	end

	// Bit collection; don't-care address bits are counted like the rest
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sh_r <= 16'h0000;
			cnt_r <= 5'h00;
		end else if (sk_rise) begin
			sh_r <= sh_nxt;
			if (at_addr || !(st_r == TWE_D_CMD || st_r == TWE_D_DATA))
				cnt_r <= 5'h00;
			else
				cnt_r <= cnt_r + 5'h01;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			adr_r <= 9'h000;
			write_all_cmd_r <= 1'b0;
		end else if (at_addr) begin
			adr_r <= adr;
			write_all_cmd_r <= opc == `TWE_OP_EXT;
		end
	end

	// Enable latch: cleared at power-up
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n)
			we_r <= 1'b0;
		else if (at_addr && opc == `TWE_OP_EXT && sub == `TWE_SUB_EN)
			we_r <= 1'b1;
		else if (at_addr && opc == `TWE_OP_EXT && sub == `TWE_SUB_DIS)
			we_r <= 1'b0;
	end

	// Programming launch; every kind needs the enable latch
	always_comb begin
		go = 1'b0;
		go_all = 1'b0;
		go_dat = `TWE_ERASED;
		go_adr = adr;
		if (at_addr && we_r && opc == `TWE_OP_ERASE)
			go = 1'b1;
		if (at_addr && we_r && opc == `TWE_OP_EXT && sub == `TWE_SUB_ERASE_ALL_CMD) begin
			go = 1'b1;
			go_all = 1'b1;
		end
		if (at_data && we_r) begin
			go = 1'b1;
			go_all = write_all_cmd_r;
			go_dat = org_r ? sh_nxt : {8'h00, sh_nxt[7:0]};
			go_adr = adr_r;
		end
	end

	// Self-timed cycle: bytes are stored one per clock, busy lasts PROG_CYC
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_r <= 1'b0;
			pt_r <= '0;
			wa_r <= 1'b0;
			pa_r <= 9'h000;
			pe_r <= 9'h000;
			pd_r <= 16'h0000;
		end else if (go) begin
			busy_r <= 1'b1;
			pt_r <= PTW'(PROG_CYC - 1);
			wa_r <= 1'b1;
			pd_r <= go_dat;
			if (go_all) begin
				pa_r <= 9'h000;
				pe_r <= `TWE_LAST_BYTE;
			end else if (org_r) begin
				pa_r <= {go_adr[7:0], 1'b0};
				pe_r <= {go_adr[7:0], 1'b1};
			end else begin
				pa_r <= go_adr;
				pe_r <= go_adr;
			end
		end else begin
			if (busy_r && pt_r == '0)
				busy_r <= 1'b0;
			else if (busy_r)
				pt_r <= pt_r - 1'b1;
			if (wa_r && pa_r == pe_r)
				wa_r <= 1'b0;
			else if (wa_r)
				pa_r <= pa_r + 9'h001;
		end
	end

	// High byte of a wide word sits at the even byte
	always_ff @(posedge core_clk) begin
		if (wa_r)
			mem_r[pa_r] <= org_r && !pa_r[0] ? pd_r[15:8] : pd_r[7:0];
	end

	// Read stream: address pointer wraps within the organisation
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ptr_r <= 9'h000;
			wd_r <= 16'h0000;
			bi_r <= 5'h00;
		end else if (at_addr && opc == `TWE_OP_READ) begin
			ptr_r <= adr;
			wd_r <= rdw(adr, org_r);
			bi_r <= 5'h00;
		end else if (st_r == TWE_D_READ && sk_rise) begin
			if (bi_r == db - 5'h01) begin
				ptr_r <= org_r ? {1'b0, ptr_r[7:0] + 8'h01} : ptr_r + 9'h001;
				wd_r <= rdw(org_r ? {1'b0, ptr_r[7:0] + 8'h01} : ptr_r + 9'h001, org_r);
				bi_r <= 5'h00;
			end else begin
				wd_r <= {wd_r[14:0], 1'b0};
				bi_r <= bi_r + 5'h01;
			end
		end
	end

	// Output: dummy zero before the first word, status when polled
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else begin
			so_oe_r <= cs_in && (st_r == TWE_D_READ || st_r == TWE_D_STAT);
			if (st_r == TWE_D_STAT)
				so_r <= ~busy_r;
			else if (st_r == TWE_D_READ && sk_rise)
				so_r <= org_r ? wd_r[15] : wd_r[7];
			else if (st_r != TWE_D_READ)
				so_r <= 1'b0;
		end
	end

	assign bus.so_o = so_r;
	assign bus.so_oe = so_oe_r;
	assign busy = busy_r;
	assign prog_enabled = we_r;
endmodule

/* File: twe_map.svh */
/*
 Constants of the three-wire serial EEPROM link: opcodes, field widths,
 array size and timing counts. Assumes a 25 MHz core clock on both ends.
*/
`ifndef TWE_MAP_SVH
`define TWE_MAP_SVH
`define TWE_OP_EXT 2'h0
`define TWE_OP_WRITE 2'h1
`define TWE_OP_READ 2'h2
`define TWE_OP_ERASE 2'h3
`define TWE_SUB_DIS 2'h0
`define TWE_SUB_WRITE_ALL_CMD 2'h1
`define TWE_SUB_ERASE_ALL_CMD 2'h2
`define TWE_SUB_EN 2'h3
`define TWE_ABITS_X8 5'h09
`define TWE_ABITS_X16 5'h08
`define TWE_DBITS_X8 5'h08
`define TWE_DBITS_X16 5'h10
`define TWE_LAST_BYTE 9'h1ff
`define TWE_ERASED 16'hffff
`define TWE_CLK_KHZ 25000
`define TWE_CLK_NS 40
`define TWE_PROG_MS 5
`define TWE_PROG_CYC (`TWE_PROG_MS * `TWE_CLK_KHZ)
`define TWE_SK_MAX_KHZ 2000
`define TWE_SK_HALF ((`TWE_CLK_KHZ + 2 * `TWE_SK_MAX_KHZ - 1) / (2 * `TWE_SK_MAX_KHZ))
`define TWE_CS_LOW_NS 250
`define TWE_CS_LOW_CYC ((`TWE_CS_LOW_NS + `TWE_CLK_NS - 1) / `TWE_CLK_NS)
`endif

/* File: twe_pkg.sv */
/*
 Types shared by both ends of the serial EEPROM link.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package twe_pkg;
	typedef enum logic [2:0] {
		TWE_CMD_READ, TWE_CMD_WRITE, TWE_CMD_ERASE, TWE_CMD_EN,
		TWE_CMD_DIS, TWE_CMD_ERASE_ALL_CMD, TWE_CMD_WRITE_ALL_CMD
	} twe_cmd_type;
	typedef enum logic [2:0] {
		TWE_D_IDLE, TWE_D_START, TWE_D_CMD, TWE_D_DATA,
		TWE_D_READ, TWE_D_STAT, TWE_D_HOLD
	} twe_dst_type;
	typedef enum logic [2:0] {
		TWE_H_IDLE, TWE_H_SEND, TWE_H_READ, TWE_H_GAP,
		TWE_H_POLL, TWE_H_END
	} twe_hst_type;
endpackage

/* File: twe_if.sv */
/*
 Serial link between the host controller and the EEPROM.
 The data-out wire floats high through a pull-up when not driven.
*/
interface twe_if;
	logic cs;
	logic sk;
	logic si;
	logic so_o;
	logic so_oe;
	logic so;
	assign so = so_oe ? so_o : 1'b1;
	modport host (output cs, output sk, output si, input so);
	modport dev (input cs, input sk, input si, output so_o, output so_oe);
endinterface

/* File: twe_host.sv */
/*
 Host end: turns one command at a time into a serial frame, collects read
 data, and polls ready/busy after programming commands.
 Assumes the device on the far side of twe_if and a 25 MHz core clock.
*/
`include "twe_map.svh"
module twe_host (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire twe_pkg::twe_cmd_type cmd_op,
	input wire logic cmd_x16,
	input wire logic [8:0] cmd_addr,
	input wire logic [15:0] cmd_data,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	twe_if.host bus
);
	import twe_pkg::*;
	twe_hst_type st_r;
	logic [27:0] sh_r;
	logic [4:0] n_r;
	logic [3:0] tm_r;
	logic so_s1_r;
	logic so_s2_r;
	logic cs_r;
	logic sk_r;
	logic si_r;
	logic rd_r;
	logic prog_r;
	logic x16_r;
	logic rdy_r;
	logic vld_r;
	logic [15:0] rsp_r;
	logic tick;
	logic [1:0] opc;
	logic [8:0] a9;
	logic ext;

	assign tick = tm_r == 4'(`TWE_SK_HALF - 1);

	always_comb begin
		ext = 1'b1;
		opc = `TWE_OP_EXT;
		a9 = {`TWE_SUB_DIS, 7'h00};
		unique case (cmd_op)
			TWE_CMD_READ: begin opc = `TWE_OP_READ; ext = 1'b0; end
			TWE_CMD_WRITE: begin opc = `TWE_OP_WRITE; ext = 1'b0; end
			TWE_CMD_ERASE: begin opc = `TWE_OP_ERASE; ext = 1'b0; end
			TWE_CMD_EN: a9 = {`TWE_SUB_EN, 7'h00};
			TWE_CMD_DIS: a9 = {`TWE_SUB_DIS, 7'h00};
			TWE_CMD_ERASE_ALL_CMD: a9 = {`TWE_SUB_ERASE_ALL_CMD, 7'h00};
			TWE_CMD_WRITE_ALL_CMD: a9 = {`TWE_SUB_WRITE_ALL_CMD, 7'h00};
		endcase
		if (!ext)
			a9 = cmd_addr;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			so_s1_r <= 1'b1;
			so_s2_r <= 1'b1;
			tm_r <= 4'h0;
		end else begin
			so_s1_r <= bus.so;
			so_s2_r <= so_s1_r;
			tm_r <= (st_r == TWE_H_IDLE || tick) ? 4'h0 : tm_r + 4'h1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= TWE_H_IDLE;
			sh_r <= 28'h0000000;
			n_r <= 5'h00;
			cs_r <= 1'b0;
			sk_r <= 1'b0;
			si_r <= 1'b0;
			rd_r <= 1'b0;
			prog_r <= 1'b0;
			x16_r <= 1'b1;
			rdy_r <= 1'b1;
			vld_r <= 1'b0;
			rsp_r <= 16'h0000;
		end else begin
			vld_r <= 1'b0;
			unique case (st_r)
				TWE_H_IDLE: if (cmd_valid) begin
					// Frame: start bit, opcode, full address field, data
					sh_r <= cmd_x16 ? {1'b1, opc, (ext ? a9[8:1] : a9[7:0]), cmd_data, 1'b0}
						: {1'b1, opc, a9, cmd_data[7:0], 8'h00};
					n_r <= 5'h03 + (cmd_x16 ? `TWE_ABITS_X16 : `TWE_ABITS_X8)
						+ ((cmd_op == TWE_CMD_WRITE || cmd_op == TWE_CMD_WRITE_ALL_CMD)
						? (cmd_x16 ? `TWE_DBITS_X16 : `TWE_DBITS_X8) : 5'h00);
					si_r <= 1'b1;
					cs_r <= 1'b1;
					sk_r <= 1'b0;
					rd_r <= cmd_op == TWE_CMD_READ;
					prog_r <= !(cmd_op == TWE_CMD_READ || cmd_op == TWE_CMD_EN
						|| cmd_op == TWE_CMD_DIS);
					x16_r <= cmd_x16;
					rsp_r <= 16'h0000;
					rdy_r <= 1'b0;
					st_r <= TWE_H_SEND;
				end
				TWE_H_SEND: if (tick) begin
					sk_r <= ~sk_r;
					if (sk_r) begin
						sh_r <= {sh_r[26:0], 1'b0};
						si_r <= sh_r[26];
						n_r <= n_r - 5'h01;
						if (n_r == 5'h01) begin
							si_r <= 1'b0;
							n_r <= 5'h01 + (x16_r ? `TWE_DBITS_X16 : `TWE_DBITS_X8);
							cs_r <= rd_r;
							st_r <= rd_r ? TWE_H_READ : (prog_r ? TWE_H_GAP : TWE_H_END);
						end
					end
				end
				TWE_H_READ: if (tick) begin
					if (!sk_r) begin
						rsp_r <= {rsp_r[14:0], so_s2_r};
						n_r <= n_r - 5'h01;
						if (n_r == 5'h01) begin
							cs_r <= 1'b0;
							vld_r <= 1'b1;
							st_r <= TWE_H_END;
						end else
							sk_r <= 1'b1;
					end else
						sk_r <= 1'b0;
				end
				TWE_H_GAP: if (tm_r == 4'(`TWE_CS_LOW_CYC - 1)) begin
					cs_r <= 1'b1;
					st_r <= TWE_H_POLL;
				end
				TWE_H_POLL: if (tick && so_s2_r) begin
					cs_r <= 1'b0;
					st_r <= TWE_H_END;
				end
				TWE_H_END: if (tm_r == 4'(`TWE_CS_LOW_CYC - 1)) begin
					rdy_r <= 1'b1;
					st_r <= TWE_H_IDLE;
				end
				default: st_r <= TWE_H_IDLE;
			endcase
		end
	end

	assign bus.cs = cs_r;
	assign bus.sk = sk_r;
	assign bus.si = si_r;
	assign cmd_ready = rdy_r;
	assign rsp_valid = vld_r;
	assign rsp_data = rsp_r;
endmodule

/* File: twe_checker.sv */
/*
 Concurrent checks on the serial EEPROM link and the device status pins.
 Assumes one core clock domain and the signals of one twe_if instance.
*/
`include "twe_map.svh"
module twe_checker #(
	parameter int unsigned PROG_CYC = `TWE_PROG_CYC
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic cs,
	input wire logic sk,
	input wire logic si,
	input wire logic so_o,
	input wire logic so_oe,
	input wire logic so,
	input wire logic busy,
	input wire logic prog_enabled
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [19:0] busy_cnt_r;
	logic first_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	// Length of the current self-timed cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_cnt_r <= 20'h0;
		end else begin
			busy_cnt_r <= busy ? busy_cnt_r + 20'h1 : 20'h0;
		end
	end

	// Marks the first serial clock rise of a frame
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			first_r <= 1'h0;
		end else if ($rose(cs)) begin
			first_r <= 1'h1;
		end else if ($rose(sk)) begin
			first_r <= 1'h0;
		end
	end

	a_prog_time: assert property (
		$fell(busy) |-> busy_cnt_r == PROG_CYC)
		else $error("programming cycle length wrong");
	a_prog_bound: assert property (
		busy_cnt_r <= PROG_CYC)
		else $error("programming cycle overran");
	a_prog_gate: assert property (
		$rose(busy) |-> prog_enabled)
		else $error("programming started while disabled");
	a_power_up: assert property (
		$rose(arst_n) |-> !prog_enabled && !busy)
		else $error("enable latch set after reset");
	a_status_busy: assert property (
		so_oe && busy |-> !so_o)
		else $error("status shows ready while busy");
	a_out_release: assert property (
		$fell(cs) |-> ##[1:5] !so_oe)
		else $error("data out still driven after deselect");
	a_start_bit: assert property (
		$rose(sk) && first_r |-> si)
		else $error("frame without start bit");
	a_clk_rest: assert property (
		!cs |-> !sk)
		else $error("serial clock moves while deselected");
	a_clk_half: assert property (
		$changed(sk) |=> $stable(sk) [*6])
		else $error("serial clock phase too short");
	a_dummy_zero: assert property (
		$rose(so_oe) && !busy |-> !so)
		else $error("read data without leading zero");

	c_prog_done: cover property ($fell(busy));
	c_status: cover property (so_oe && busy);
	c_read: cover property ($rose(so_oe) && !busy);
	c_enable: cover property ($rose(prog_enabled));
endmodule

/* File: tb.sv */
/*
 Self-checking bench: host and device ends joined through twe_if.
 Assumes the design files are compiled before it.
*/
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import twe_pkg::*;
	typedef struct {
		twe_cmd_type op;
		logic x16;
		logic [8:0] a;
		logic [15:0] d;
		logic [15:0] q;
		logic en;
		logic bz;
	} twe_row_type;
	localparam int unsigned PROG = 600;
	logic core_clk = 1'h0;
	logic arst_n = 1'h0;
	logic width_select = 1'h1;
	logic cmd_valid = 1'h0;
	twe_cmd_type cmd_op = TWE_CMD_READ;
	logic cmd_x16 = 1'h1;
	logic [8:0] cmd_addr = 9'h0;
	logic [15:0] cmd_data = 16'h0;
	logic busy, prog_enabled, cmd_ready, rsp_valid, got_rsp, busy_seen;
	logic [15:0] rsp_data;
	int n_fail = 0;
	int tests_run = 0;
	int cyc = 0;
	twe_row_type rows [22];

	twe_if i_twe_if();
	twe_dev #(.PROG_CYC(PROG)) i_twe_dev(.core_clk(core_clk),
		.arst_n(arst_n), .width_select(width_select), .busy(busy),
		.prog_enabled(prog_enabled), .bus(i_twe_if));
	twe_host i_twe_host(.core_clk(core_clk), .arst_n(arst_n),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_x16(cmd_x16), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .bus(i_twe_if));
	twe_checker #(.PROG_CYC(PROG)) i_twe_checker(.core_clk(core_clk),
		.arst_n(arst_n), .cs(i_twe_if.cs), .sk(i_twe_if.sk),
		.si(i_twe_if.si), .so_o(i_twe_if.so_o), .so_oe(i_twe_if.so_oe),
		.so(i_twe_if.so), .busy(busy), .prog_enabled(prog_enabled));

	always #20 core_clk = ~core_clk;

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("checks=%0d errors=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// One command through the host; notes response and busy activity
	task automatic send(input twe_row_type r);
		logic seen;
		seen = 1'h0;
		got_rsp = 1'h0;
		busy_seen = 1'h0;
		@(negedge core_clk);
		if (width_select !== r.x16) begin
			width_select = r.x16;
			repeat (6) @(negedge core_clk);
		end
		cmd_valid = 1'h1;
		cmd_op = r.op;
		cmd_x16 = r.x16;
		cmd_addr = r.a;
		cmd_data = r.d;
		@(negedge core_clk);
		cmd_valid = 1'h0;
		for (int k = 0; k < 4000 && !(seen && cmd_ready); k++) begin
			@(negedge core_clk);
			seen |= !cmd_ready;
			got_rsp |= rsp_valid;
			busy_seen |= busy;
		end
		// A command that never completes counts as a mismatch
		if (!(seen && cmd_ready)) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end
	endtask

	initial begin
		rows = '{
			'{TWE_CMD_EN, 1'h1, 9'h0, 16'h0, 16'h0, 1'h1, 1'h0},
			'{TWE_CMD_WRITE, 1'h1, 9'h5, 16'h1234, 16'h0, 1'h1, 1'h1},
			'{TWE_CMD_READ, 1'h1, 9'h5, 16'h0, 16'h1234, 1'h1, 1'h0},
			'{TWE_CMD_ERASE, 1'h1, 9'h5, 16'h0, 16'h0, 1'h1, 1'h1},
			'{TWE_CMD_READ, 1'h1, 9'h5, 16'h0, 16'hffff, 1'h1, 1'h0},
			'{TWE_CMD_WRITE, 1'h1, 9'hff, 16'ha55a, 16'h0, 1'h1, 1'h1},
			'{TWE_CMD_READ, 1'h1, 9'hff, 16'h0, 16'ha55a, 1'h1, 1'h0},
			'{TWE_CMD_DIS, 1'h1, 9'h0, 16'h0, 16'h0, 1'h0, 1'h0},
			'{TWE_CMD_WRITE, 1'h1, 9'h5, 16'h0, 16'h0, 1'h0, 1'h0},
			'{TWE_CMD_READ, 1'h1, 9'h5, 16'h0, 16'hffff, 1'h0, 1'h0},
			'{TWE_CMD_ERASE_ALL_CMD, 1'h1, 9'h0, 16'h0, 16'h0, 1'h0, 1'h0},
			'{TWE_CMD_READ, 1'h1, 9'hff, 16'h0, 16'ha55a, 1'h0, 1'h0},
			'{TWE_CMD_EN, 1'h1, 9'h0, 16'h0, 16'h0, 1'h1, 1'h0},
			'{TWE_CMD_WRITE_ALL_CMD, 1'h1, 9'h0, 16'h0f0f, 16'h0, 1'h1, 1'h1},
			'{TWE_CMD_READ, 1'h1, 9'h80, 16'h0, 16'h0f0f, 1'h1, 1'h0},
			'{TWE_CMD_ERASE_ALL_CMD, 1'h1, 9'h0, 16'h0, 16'h0, 1'h1, 1'h1},
			'{TWE_CMD_READ, 1'h1, 9'h0, 16'h0, 16'hffff, 1'h1, 1'h0},
			'{TWE_CMD_WRITE, 1'h0, 9'h1ff, 16'h3c, 16'h0, 1'h1, 1'h1},
			'{TWE_CMD_READ, 1'h0, 9'h1ff, 16'h0, 16'h3c, 1'h1, 1'h0},
			'{TWE_CMD_READ, 1'h0, 9'h1fe, 16'h0, 16'hff, 1'h1, 1'h0},
			'{TWE_CMD_READ, 1'h1, 9'hff, 16'h0, 16'hff3c, 1'h1, 1'h0},
			'{TWE_CMD_DIS, 1'h1, 9'h0, 16'h0, 16'h0, 1'h0, 1'h0}};
		repeat (5) @(negedge core_clk);
		arst_n = 1'h1;
		repeat (4) @(negedge core_clk);
		chk({15'h0, prog_enabled}, 16'h0);
		foreach (rows[i]) begin
			send(rows[i]);
			if (rows[i].op == TWE_CMD_READ) begin
				chk(rsp_data, rows[i].q);
			end
			chk({15'h0, got_rsp}, {15'h0, rows[i].op == TWE_CMD_READ});
			chk({15'h0, prog_enabled}, {15'h0, rows[i].en});
			chk({15'h0, busy_seen}, {15'h0, rows[i].bz});
		end
		// Reset in mid-run with programming enabled
		send(rows[0]);
		@(negedge core_clk);
		arst_n = 1'h0;
		repeat (2) @(negedge core_clk);
		arst_n = 1'h1;
		chk({14'h0, prog_enabled, cmd_ready}, 16'h1);
		repeat (4) @(negedge core_clk);
		send(rows[1]);
		chk({15'h0, busy_seen}, 16'h0);
		send(rows[9]);
		chk(rsp_data, rows[9].q);
		results();
	end

	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			results();
		end
	end
endmodule
